// ---- hw/tcc_consts.svh ----
// How it works
// - Normal frequency: 8-bit uses period, else maximum
// - Normal frequency: match toggles output, sets flag
// - Match frequency: channel zero is period, toggles
// - PWM up: set at top, clear on match
// - PWM down: clear at zero, set on match
// - Status reports PWM resolution from top value
// - Enable bit starts and stops the timer
// - Soft reset clears all but debug control
// - Prescaler divides clock from one to 1024
// - Sync bit picks clock or prescaled update
// - Event counting bypasses the prescaler
// - Each tick clears, reloads, increments or decrements
// - Direction bit zero up, one down
// - Up at top: load zero, set overflow
// - Down at zero: reload top, set overflow
// - Overflow drives interrupt, DMA and event
// - One-shot stops counting on wrap
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH
`define NUM_CH 2
`define OFF_CTRL_A 8'h00
`define OFF_CTRL_B 8'h04
`define OFF_FLAGS 8'h08
`define OFF_MASK 8'h0c
`define OFF_COUNT 8'h10
`define OFF_PERIOD 8'h14
`define OFF_CC0 8'h18
`define OFF_CC1 8'h1c
`define OFF_STATUS 8'h20
`define OFF_DEBUG 8'h24
`define CA_SOFT_RESET_BIT 0
`define CA_ENABLE 1
`define CA_PRESC_LO 2
`define CA_PRESC_HI 4
`define CA_SYNC 5
`define CA_WIDTH_LO 6
`define CA_WIDTH_HI 7
`define CB_DIR 0
`define CB_SINGLE_CYCLE_BIT 1
`define CB_MODE_LO 2
`define CB_MODE_HI 3
`define CB_EVENTS 4
`define FL_OVF 0
`define FL_W 3
`define MAX8 32'h0000_00ff
`define MAX16 32'h0000_ffff
`define MAX32 32'hffff_ffff
`define WIDTH8 2'h0
`define WIDTH16 2'h1
`define PRESC_W 10
`define DIV_0 11'h001
`define DIV_1 11'h002
`define DIV_2 11'h004
`define DIV_3 11'h008
`define DIV_4 11'h010
`define DIV_5 11'h040
`define DIV_6 11'h100
`define DIV_7 11'h400
`define ST_RES_LO 0
`define ST_RES_HI 5
`define ST_ENABLE 6
`define ST_WAVE_LO 7
`define ST_WAVE_HI 8
`define ST_PEND 9
`endif

// ---- hw/tcc_pkg.sv ----
package tcc_pkg;
	typedef enum logic [1:0] {
		normal_frequency_mode,
		match_frequency_mode,
		single_slope_pwm_mode,
		mode_reserved
	} wave_mode_e;
	typedef struct packed {
		logic [9:0] cnt;
		logic tick;
	} presc_state_s;
	typedef struct packed {
		logic wait_req;
		logic [31:0] rdata;
		logic enable;
		logic [2:0] presc;
		logic sync_sel;
		logic [1:0] width;
		logic dir;
		logic one_shot;
		logic [1:0] mode;
		logic evt_mode;
		logic [31:0] count;
		logic [31:0] period;
		logic [1:0][31:0] cc;
		logic [2:0] flags;
		logic [2:0] mask;
		logic [1:0] wave;
		logic irq;
		logic dma;
		logic evt;
		logic dbg_halt;
		logic pend;
		logic [31:0] pend_val;
	} tcc_state_s;
endpackage

// ---- hw/tcc_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"
module tcc_prescaler import tcc_pkg::*; (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic run_in,
	input wire logic [2:0] sel_in,
	output logic tick_out
);
	presc_state_s q, d;

	// Division factor per select code
	function automatic logic [10:0] divisor(input logic [2:0] s);
		unique case (s)
			3'h0: divisor = `DIV_0;
			3'h1: divisor = `DIV_1;
			3'h2: divisor = `DIV_2;
			3'h3: divisor = `DIV_3;
			3'h4: divisor = `DIV_4;
			3'h5: divisor = `DIV_5;
			3'h6: divisor = `DIV_6;
			default: divisor = `DIV_7;
		endcase
	endfunction

	// Count to one below the divisor, pulse on reaching it; idle when stopped
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (!run_in) begin
			d.cnt = '0;
		end else if ({1'b0, q.cnt} >= 11'(divisor(sel_in) - 11'h1)) begin
			d.cnt = '0;
			d.tick = 1'b1;
		end else begin
			d.cnt = 10'(q.cnt + 10'h1);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick_out = q.tick;
endmodule
`default_nettype wire

// ---- hw/tcc_core.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"
module tcc_core import tcc_pkg::*; (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [7:0] av_address_in,
	input wire logic av_read_in,
	input wire logic av_write_in,
	input wire logic [31:0] av_writedata_in,
	output logic [31:0] av_readdata_out,
	output logic av_waitrequest_out,
	input wire logic count_event_in,
	input wire logic debug_halt_in,
	output logic [1:0] waveform_out,
	output logic irq_out,
	output logic dma_req_out,
	output logic event_out
);
	localparam tcc_state_s RST_S = '{wait_req: 1'b1, default: '0};

	tcc_state_s q, d;
	logic presc_tick, tick, adv, wrap, is_top, done;
	logic [31:0] top;
	logic [1:0] match;

	// Largest count the selected width can hold
	function automatic logic [31:0] wmax(input logic [1:0] w);
		unique case (w)
			`WIDTH8: wmax = `MAX8;
			`WIDTH16: wmax = `MAX16;
			default: wmax = `MAX32;
		endcase
	endfunction

	// Period source follows mode and width
	function automatic logic [31:0] top_value(input tcc_state_s s);
		if (wave_mode_e'(s.mode) == match_frequency_mode) begin
			top_value = s.cc[0] & wmax(s.width);
		end else if (s.width == `WIDTH8) begin
			top_value = s.period & `MAX8;
		end else begin
			top_value = wmax(s.width);
		end
	endfunction

	// Floor of log2(top+1); exact for the usual 2^n-1 tops
	function automatic logic [5:0] resolution(input logic [31:0] t);
		logic [32:0] t1;
		resolution = '0;
		t1 = 33'({1'b0, t} + 33'h1);
		for (int i = 0; i < 33; i++) begin
			if (t1[i]) begin
				resolution = 6'(i);
			end
		end
	endfunction

	// Prescaler idles in event mode so it cannot leak ticks
	tcc_prescaler u_presc (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.run_in(q.enable && !q.evt_mode),
		.sel_in(q.presc),
		.tick_out(presc_tick)
	);

	// Joint tick stream and counting gate
	assign tick = q.evt_mode ? count_event_in : presc_tick;
	assign adv = q.enable && !(q.dbg_halt && debug_halt_in) && tick
		&& !(q.pend && presc_tick);
	assign top = top_value(q);
	assign is_top = q.dir ? (q.count == 32'h0) : (q.count == top);
	assign wrap = adv && is_top;
	assign done = (av_read_in || av_write_in) && !q.wait_req;

	// Compare channels, only on an advancing tick
	always_comb begin
		for (int c = 0; c < `NUM_CH; c++) begin
			match[c] = adv && (q.count == q.cc[c]);
		end
	end

	// Next state: counter, waveforms, bus, flags, soft reset
	always_comb begin
		d = q;
		d.evt = 1'b0;
		d.dma = 1'b0;
		// Waitrequest drops for exactly one cycle per request
		d.wait_req = !((av_read_in || av_write_in) && q.wait_req);
		// A tick left over after disable must not move a held count
		if (q.pend && presc_tick && q.enable) begin
			d.count = q.pend_val;
			d.pend = 1'b0;
		end else if (adv) begin
			if (wrap) begin
				d.count = q.dir ? top : 32'h0;
			end else if (q.dir) begin
				d.count = 32'(q.count - 32'h1);
			end else begin
				d.count = 32'(q.count + 32'h1);
			end
		end
		if (wrap) begin
			d.evt = 1'b1;
			d.dma = 1'b1;
			if (q.one_shot) begin
				d.enable = 1'b0;
			end
		end
		unique case (wave_mode_e'(q.mode))
			match_frequency_mode: begin
				if (wrap) begin
					d.wave[0] = !q.wave[0];
				end
			end
			single_slope_pwm_mode: begin
				for (int c = 0; c < `NUM_CH; c++) begin
					if (wrap) begin
						d.wave[c] = !q.dir;
					end else if (match[c]) begin
						d.wave[c] = q.dir;
					end
				end
			end
			default: begin
				for (int c = 0; c < `NUM_CH; c++) begin
					if (match[c]) begin
						d.wave[c] = !q.wave[c];
					end
				end
			end
		endcase
		// Read data is latched when waitrequest falls
		if ((av_read_in || av_write_in) && q.wait_req) begin
			d.rdata = '0;
			unique case (av_address_in)
				`OFF_CTRL_A: begin
					d.rdata[`CA_ENABLE] = q.enable;
					d.rdata[`CA_PRESC_HI:`CA_PRESC_LO] = q.presc;
					d.rdata[`CA_SYNC] = q.sync_sel;
					d.rdata[`CA_WIDTH_HI:`CA_WIDTH_LO] = q.width;
				end
				`OFF_CTRL_B: begin
					d.rdata[`CB_DIR] = q.dir;
					d.rdata[`CB_SINGLE_CYCLE_BIT] = q.one_shot;
					d.rdata[`CB_MODE_HI:`CB_MODE_LO] = q.mode;
					d.rdata[`CB_EVENTS] = q.evt_mode;
				end
				`OFF_FLAGS: d.rdata[`FL_W-1:0] = q.flags;
				`OFF_MASK: d.rdata[`FL_W-1:0] = q.mask;
				`OFF_COUNT: d.rdata = q.count;
				`OFF_PERIOD: d.rdata = q.period;
				`OFF_CC0: d.rdata = q.cc[0];
				`OFF_CC1: d.rdata = q.cc[1];
				`OFF_STATUS: begin
					d.rdata[`ST_RES_HI:`ST_RES_LO] = resolution(top);
					d.rdata[`ST_ENABLE] = q.enable;
					d.rdata[`ST_WAVE_HI:`ST_WAVE_LO] = q.wave;
					d.rdata[`ST_PEND] = q.pend;
				end
				`OFF_DEBUG: d.rdata[0] = q.dbg_halt;
				default: d.rdata = '0;
			endcase
		end
		// Writes land on the edge that ends the request
		if (done && av_write_in) begin
			unique case (av_address_in)
				`OFF_CTRL_A: begin
					d.enable = av_writedata_in[`CA_ENABLE];
					d.presc = av_writedata_in[`CA_PRESC_HI:`CA_PRESC_LO];
					d.sync_sel = av_writedata_in[`CA_SYNC];
					d.width = av_writedata_in[`CA_WIDTH_HI:`CA_WIDTH_LO];
					if (av_writedata_in[`CA_ENABLE] && !q.enable
						&& wave_mode_e'(q.mode) == single_slope_pwm_mode) begin
						d.wave = {`NUM_CH{!q.dir}};
					end
				end
				`OFF_CTRL_B: begin
					d.dir = av_writedata_in[`CB_DIR];
					d.one_shot = av_writedata_in[`CB_SINGLE_CYCLE_BIT];
					d.mode = av_writedata_in[`CB_MODE_HI:`CB_MODE_LO];
					d.evt_mode = av_writedata_in[`CB_EVENTS];
				end
				`OFF_MASK: d.mask = av_writedata_in[`FL_W-1:0];
				`OFF_COUNT: begin
					// Deferred load keeps the prescaled phase intact
					if (q.sync_sel && q.presc != 3'h0 && !q.evt_mode
						&& q.enable) begin
						d.pend = 1'b1;
						d.pend_val = av_writedata_in;
					end else begin
						d.count = av_writedata_in;
					end
				end
				`OFF_PERIOD: d.period = av_writedata_in;
				`OFF_CC0: d.cc[0] = av_writedata_in;
				`OFF_CC1: d.cc[1] = av_writedata_in;
				`OFF_DEBUG: d.dbg_halt = av_writedata_in[0];
				default: d.period = q.period;
			endcase
		end
		// Read clears only the bits it reported; new events still set
		if (done && av_read_in && av_address_in == `OFF_FLAGS) begin
			d.flags = q.flags & ~q.rdata[`FL_W-1:0];
		end
		d.flags = d.flags | {match, wrap};
		// Soft reset wipes everything except debug control
		if (done && av_write_in && av_address_in == `OFF_CTRL_A
			&& av_writedata_in[`CA_SOFT_RESET_BIT]) begin
			d = RST_S;
			d.dbg_halt = q.dbg_halt;
		end
		d.irq = |(d.flags & d.mask);
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			q <= RST_S;
		end else begin
			q <= d;
		end
	end

	assign av_readdata_out = q.rdata;
	assign av_waitrequest_out = q.wait_req;
	assign waveform_out = q.wave;
	assign irq_out = q.irq;
	assign dma_req_out = q.dma;
	assign event_out = q.evt;

	// Checks on the registered state
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	logic wr_ctrl_a;
	assign wr_ctrl_a = done && av_write_in && av_address_in == `OFF_CTRL_A;

	property p_up_wrap;
		adv && !q.dir && is_top && !done |=> q.count == 32'h0 && q.flags[`FL_OVF];
	endproperty
	a_up_wrap: assert property (p_up_wrap) else $error("up wrap failed");

	property p_down_wrap;
		logic [31:0] t;
		(adv && q.dir && is_top && !done, t = top) |=> q.count == t && q.flags[0];
	endproperty
	a_down_wrap: assert property (p_down_wrap) else $error("down reload failed");

	property p_one_shot;
		wrap && q.one_shot && !wr_ctrl_a |=> !q.enable ##1 !q.enable;
	endproperty
	a_one_shot: assert property (p_one_shot) else $error("one-shot kept running");

	property p_hold;
		!q.enable && !(done && av_write_in) |=> $stable(q.count) && $stable(q.wave);
	endproperty
	a_hold: assert property (p_hold) else $error("disabled timer moved");

	property p_normal_frequency_mode_toggle;
		match[0] && wave_mode_e'(q.mode) == normal_frequency_mode
			|=> q.wave[0] != $past(q.wave[0]) && q.flags[1];
	endproperty
	a_normal_frequency_mode_toggle: assert property (p_normal_frequency_mode_toggle) else $error("no toggle");

	property p_pwm_up;
		wrap && !q.dir && wave_mode_e'(q.mode) == single_slope_pwm_mode
			&& !wr_ctrl_a |=> waveform_out == {`NUM_CH{1'b1}};
	endproperty
	a_pwm_up: assert property (p_pwm_up) else $error("pwm up not set");

	property p_pwm_down;
		wrap && q.dir && wave_mode_e'(q.mode) == single_slope_pwm_mode
			&& !wr_ctrl_a |=> waveform_out == '0;
	endproperty
	a_pwm_down: assert property (p_pwm_down) else $error("pwm down not cleared");

	property p_enable;
		wr_ctrl_a && !av_writedata_in[`CA_SOFT_RESET_BIT]
			|=> q.enable == $past(av_writedata_in[`CA_ENABLE]);
	endproperty
	a_enable: assert property (p_enable) else $error("enable not taken");

	property p_soft_reset_bit;
		wr_ctrl_a && av_writedata_in[`CA_SOFT_RESET_BIT]
			|=> !q.enable && q.count == 32'h0 && $stable(q.dbg_halt);
	endproperty
	a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("soft reset incomplete");

	property p_ovf_out;
		wrap |=> event_out && dma_req_out ##1 (!event_out || $past(wrap));
	endproperty
	a_ovf_out: assert property (p_ovf_out) else $error("overflow not signalled");

	property p_ack;
		!av_waitrequest_out |=> av_waitrequest_out;
	endproperty
	a_ack: assert property (p_ack) else $error("waitrequest low twice");

	c_up_wrap: cover property (wrap && !q.dir);
	c_down_wrap: cover property (wrap && q.dir);
	c_soft_reset_bit: cover property (wr_ctrl_a && av_writedata_in[`CA_SOFT_RESET_BIT]);
	c_pwm: cover property (match[0] && q.mode == 2'h2);
endmodule
`default_nettype wire

// ---- bench/tb_tcc_core.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"
module tb_tcc_core import tcc_pkg::*;;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] av_address_in = 8'h00;
	logic av_read_in = 1'b0;
	logic av_write_in = 1'b0;
	logic [31:0] av_writedata_in = 32'h0;
	logic [31:0] av_readdata_out;
	logic av_waitrequest_out;
	logic count_event_in = 1'b0;
	logic debug_halt_in = 1'b0;
	logic [1:0] waveform_out;
	logic irq_out, dma_req_out, event_out;
	int n_errors = 0;
	int cmp_count = 0;
	tcc_core i_tcc_core (.mclk_in(mclk_in), .rst_in(rst_in),
		.av_address_in(av_address_in), .av_read_in(av_read_in),
		.av_write_in(av_write_in), .av_writedata_in(av_writedata_in),
		.av_readdata_out(av_readdata_out),
		.av_waitrequest_out(av_waitrequest_out),
		.count_event_in(count_event_in), .debug_halt_in(debug_halt_in),
		.waveform_out(waveform_out), .irq_out(irq_out),
		.dma_req_out(dma_req_out), .event_out(event_out));
	// 200 MHz clock
	always #2.5 mclk_in = ~mclk_in;
	task report_and_stop;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task timeout;
		n_errors++;
		$display("wait limit hit at %0t", $time);
		report_and_stop;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One Avalon transfer; request held until waitrequest seen low
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int i;
		@(posedge mclk_in);
		av_address_in <= a;
		av_writedata_in <= d;
		av_write_in <= wr;
		av_read_in <= ~wr;
		for (i = 0; i < 20; i++) begin
			@(posedge mclk_in);
			if (av_waitrequest_out === 1'b0) break;
		end
		if (i == 20) timeout;
		q = av_readdata_out;
		av_write_in <= 1'b0;
		av_read_in <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q & m, e);
	endtask
	task idle(input int n);
		repeat (n) @(posedge mclk_in);
	endtask
	// n event ticks, each followed by settle time for the outputs
	task pulse(input int n);
		repeat (n) begin
			@(posedge mclk_in);
			count_event_in <= 1'b1;
			@(posedge mclk_in);
			count_event_in <= 1'b0;
			idle(2);
		end
	endtask
	// Disable before soft reset so no count is caught mid-update
	task fresh;
		wr(`OFF_CTRL_A, 32'h0);
		wr(`OFF_CTRL_A, 32'h1);
	endtask
	task wait_ovf(output int n);
		for (n = 0; n < 5000; n++) begin
			@(posedge mclk_in);
			if (event_out === 1'b1) break;
		end
		if (n == 5000) timeout;
		chk(dma_req_out, 1'b1);
	endtask
	task t_reset;
		rd(`OFF_CTRL_A, 32'hffffffff, 32'h0);
		rd(`OFF_COUNT, 32'hffffffff, 32'h0);
		wr(8'h40, 32'h5a);
		rd(8'h40, 32'hffffffff, 32'h0);
	endtask
	// Overflow spacing is four ticks at prescale settings 0, 2 and 7
	task t_prescale;
		int sel[3] = '{0, 2, 7};
		int dv[3] = '{1, 4, 1024};
		int n;
		for (int k = 0; k < 3; k++) begin
			fresh;
			wr(`OFF_PERIOD, 32'h3);
			wr(`OFF_MASK, 32'h1);
			wr(`OFF_CTRL_A, 32'h2 | (sel[k] << 2));
			wait_ovf(n);
			chk(irq_out, 1'b1);
			wait_ovf(n);
			chk(n + 1, 4 * dv[k]);
			wr(`OFF_CTRL_A, 32'h0);
			rd(`OFF_FLAGS, 32'h1, 32'h1);
			rd(`OFF_FLAGS, 32'h1, 32'h0);
			idle(2);
			chk(irq_out, 1'b0);
		end
	endtask
	task t_up16;
		fresh;
		wr(`OFF_CTRL_B, 32'h12);
		wr(`OFF_PERIOD, 32'h2);
		wr(`OFF_COUNT, 32'hfffe);
		wr(`OFF_CTRL_A, 32'h42);
		pulse(2);
		rd(`OFF_COUNT, 32'hffffffff, 32'h0);
		rd(`OFF_STATUS, 32'h40, 32'h0);
		pulse(1);
		rd(`OFF_COUNT, 32'hffffffff, 32'h0);
	endtask
	task t_down;
		fresh;
		wr(`OFF_CTRL_B, 32'h13);
		wr(`OFF_PERIOD, 32'h5);
		wr(`OFF_COUNT, 32'h1);
		wr(`OFF_CTRL_A, 32'h2);
		pulse(2);
		rd(`OFF_COUNT, 32'hffffffff, 32'h5);
		rd(`OFF_FLAGS, 32'h1, 32'h1);
	endtask
	// Zero compare on channel 0 toggles it too
	task t_normal;
		fresh;
		wr(`OFF_CTRL_B, 32'h10);
		wr(`OFF_PERIOD, 32'hff);
		wr(`OFF_CC1, 32'h2);
		wr(`OFF_CTRL_A, 32'h2);
		pulse(3);
		chk(waveform_out, 2'h3);
		rd(`OFF_FLAGS, 32'h7, 32'h6);
		rd(`OFF_COUNT, 32'hffffffff, 32'h3);
	endtask
	task t_match;
		fresh;
		wr(`OFF_CTRL_B, 32'h14);
		wr(`OFF_CC0, 32'h1);
		wr(`OFF_CTRL_A, 32'h2);
		pulse(1);
		chk(waveform_out[0], 1'b0);
		pulse(1);
		chk(waveform_out[0], 1'b1);
		rd(`OFF_COUNT, 32'hffffffff, 32'h0);
	endtask
	task t_pwm;
		fresh;
		wr(`OFF_CTRL_B, 32'h18);
		wr(`OFF_PERIOD, 32'h4);
		wr(`OFF_CC0, 32'h2);
		wr(`OFF_CTRL_A, 32'h2);
		idle(2);
		chk(waveform_out[0], 1'b1);
		rd(`OFF_STATUS, 32'h3f, 32'h2);
		pulse(3);
		chk(waveform_out[0], 1'b0);
		pulse(2);
		chk(waveform_out[0], 1'b1);
		fresh;
		wr(`OFF_CTRL_B, 32'h19);
		wr(`OFF_PERIOD, 32'h4);
		wr(`OFF_CC0, 32'h2);
		wr(`OFF_COUNT, 32'h3);
		wr(`OFF_CTRL_A, 32'h2);
		idle(2);
		chk(waveform_out[0], 1'b0);
		pulse(2);
		chk(waveform_out[0], 1'b1);
		pulse(2);
		chk(waveform_out[0], 1'b0);
	endtask
	// Synced count load waits for the next /1024 tick
	task t_sync;
		fresh;
		wr(`OFF_CTRL_B, 32'h0);
		wr(`OFF_PERIOD, 32'hff);
		wr(`OFF_CTRL_A, 32'h3e);
		wr(`OFF_COUNT, 32'h50);
		rd(`OFF_STATUS, 32'h200, 32'h200);
		rd(`OFF_COUNT, 32'hffffffff, 32'h0);
		idle(1030);
		rd(`OFF_COUNT, 32'hffffffff, 32'h50);
		rd(`OFF_STATUS, 32'h200, 32'h0);
		wr(`OFF_CTRL_A, 32'h0);
	endtask
	task t_srst;
		wr(`OFF_DEBUG, 32'h1);
		wr(`OFF_PERIOD, 32'h7);
		fresh;
		rd(`OFF_PERIOD, 32'hffffffff, 32'h0);
		rd(`OFF_DEBUG, 32'h1, 32'h1);
		wr(`OFF_DEBUG, 32'h0);
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge mclk_in);
		rst_in <= 1'b0;
		t_reset;
		t_srst;
		t_prescale;
		t_up16;
		t_down;
		t_normal;
		t_match;
		t_pwm;
		t_sync;
		report_and_stop;
	end
endmodule
`default_nettype wire
